// ### core/lpt_pkg.sv
package lpt_pkg;

    // register offsets
    localparam logic [7:0] ADDR_STATUS    = 8'h00;
    localparam logic [7:0] ADDR_MAIN_CFG  = 8'h01;
    localparam logic [7:0] ADDR_AMB_UP_HI = 8'h06;
    localparam logic [7:0] ADDR_AMB_UP_LO = 8'h07;
    localparam logic [7:0] ADDR_AMB_LO_HI = 8'h08;
    localparam logic [7:0] ADDR_AMB_LO_LO = 8'h09;
    localparam logic [7:0] ADDR_PERSIST   = 8'h0A;
    localparam logic [7:0] ADDR_PROX_DIR  = 8'h0B;
    localparam logic [7:0] ADDR_PROX_LIM  = 8'h0C;
    localparam logic [7:0] ADDR_GREEN_ADJ = 8'h0F;
    localparam logic [7:0] ADDR_IR_ADJ    = 8'h10;

    // field positions
    localparam int AMB_EN_BIT     = 0;
    localparam int PROX_EN_BIT    = 1;
    localparam int TRIM_SEL_BIT   = 5;
    localparam int AMB_FLAG_BIT   = 0;
    localparam int PROX_FLAG_BIT  = 1;
    localparam int PWR_FLAG_BIT   = 2;
    localparam int PROX_DIR_BIT   = 6;
    localparam int LIMIT_W        = 14;
    localparam int LIMIT_HI_W     = 6;
    localparam int PROX_W         = 8;
    localparam int GREEN_GAIN_W   = 7;
    localparam int IR_GAIN_W      = 9;
    localparam int CNT_W          = 5;

    // reset values
    localparam logic [7:0] REG_RST      = 8'h00;
    localparam logic [7:0] TRIM_RST     = 8'h80;
    localparam logic [7:0] MAIN_CFG_RST = 8'h20;

    // persistence selector decode
    localparam logic [CNT_W-1:0] PERS_CNT_00 = 5'h01;
    localparam logic [CNT_W-1:0] PERS_CNT_01 = 5'h02;
    localparam logic [CNT_W-1:0] PERS_CNT_10 = 5'h04;
    localparam logic [CNT_W-1:0] PERS_CNT_11 = 5'h10;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } lpt_pers_s;

    typedef struct packed {
        logic [LIMIT_W-1:0]      amb_up;
        logic [LIMIT_W-1:0]      amb_lo;
        logic [3:0]              persist;
        logic                    prox_above;
        logic [PROX_W-1:0]       prox_limit;
        logic [7:0]              main_cfg;
        logic [7:0]              green_adj;
        logic [7:0]              ir_adj;
        logic                    amb_flag;
        logic                    prox_flag;
        logic                    pwr_flag;
        logic                    irq_oe;
        logic [7:0]              rdata;
        logic [GREEN_GAIN_W-1:0] green_gain;
        logic [IR_GAIN_W-1:0]    ir_gain;
    } lpt_state_s;

    function automatic logic [CNT_W-1:0] pers_need(input logic [1:0] sel);
        case (sel)
            2'h0:    pers_need = PERS_CNT_00;
            2'h1:    pers_need = PERS_CNT_01;
            2'h2:    pers_need = PERS_CNT_10;
            default: pers_need = PERS_CNT_11;
        endcase
    endfunction : pers_need

endpackage : lpt_pkg

// ### core/lpt_persist.sv
`timescale 1ns/100ps
module lpt_persist (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       enable,
    input  wire logic       sample,
    input  wire logic       hit,
    input  wire logic [1:0] sel,
    output logic            fire
);
    lpt_pkg::lpt_pers_s            s_q;
    lpt_pkg::lpt_pers_s            s_d;
    logic [lpt_pkg::CNT_W-1:0]     need;
    logic [lpt_pkg::CNT_W-1:0]     inc;

    always_comb begin
        need = lpt_pkg::pers_need(sel);
        inc  = s_q.cnt + 5'h01;
        s_d  = s_q;
        fire = 1'b0;
        if (!enable) begin
            s_d.cnt = '0;
        end else if (sample) begin
            if (hit) begin
                // saturate so a long run of events cannot wrap and re-arm
                if (s_q.cnt < need) begin
                    s_d.cnt = inc;
                end
                fire = (inc >= need);
            end else begin
                s_d.cnt = '0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q.cnt <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : lpt_persist

// ### core/lpt_core.sv
// Contract
// - ambient upper and lower limits, byte pairs
// - limit high bytes keep only six bits
// - ambient beyond window, qualified, sets flag
// - selector decodes to 1, 2, 4, 16
// - non-event measurement zeroes channel counter
// - selector 00 flags on first event
// - proximity uses own selector and counter
// - persistence register: prox 3:2, ambient 1:0
// - direction one: event when result above limit
// - direction zero: event when result below limit
// - proximity flag only after persistence satisfied
// - gain trim reads return complement
// - user trims used only while select zero
// - green 7-bit, ir 9-bit trims, reset 0x80
// - overrange raises ambient interrupt when enabled
// - enables at main config bits 0, 1
// - interrupt pin open drain, active low
// - status read or disable clears flags
// - power restart flag set by reset
// - ambient result is green minus ir
// - status bit 0 ambient, bit 1 prox
// - disabled channel not compared, flag low
`timescale 1ns/100ps
module lpt_core (
    input  wire logic                              clock,
    input  wire logic                              rst_n,
    input  wire logic [7:0]                        reg_addr,
    input  wire logic                              reg_wr,
    input  wire logic [7:0]                        reg_wdata,
    input  wire logic                              reg_rd,
    output logic [7:0]                             reg_rdata,
    input  wire logic                              amb_done,
    input  wire logic [lpt_pkg::LIMIT_W-1:0]       green_data,
    input  wire logic [lpt_pkg::LIMIT_W-1:0]       ir_data,
    input  wire logic                              ambient_overrange,
    input  wire logic                              prox_done,
    input  wire logic [lpt_pkg::PROX_W-1:0]        prox_data,
    input  wire logic [lpt_pkg::GREEN_GAIN_W-1:0]  factory_green,
    input  wire logic [lpt_pkg::IR_GAIN_W-1:0]     factory_ir,
    output logic                                   irq_n_out,
    output logic                                   irq_n_oe,
    output logic [lpt_pkg::GREEN_GAIN_W-1:0]       green_gain,
    output logic [lpt_pkg::IR_GAIN_W-1:0]          ir_gain
);
    lpt_pkg::lpt_state_s               s_q;
    lpt_pkg::lpt_state_s               s_d;
    logic                              amb_en;
    logic                              prox_en;
    logic [lpt_pkg::LIMIT_W:0]         amb_diff;
    logic [lpt_pkg::LIMIT_W-1:0]       amb_value;
    logic                              amb_hit;
    logic                              prox_hit;
    logic                              amb_fire;
    logic                              prox_fire;
    logic                              stat_rd;
    logic                              irq_oe_hold;

    assign amb_en  = s_q.main_cfg[lpt_pkg::AMB_EN_BIT];
    assign prox_en = s_q.main_cfg[lpt_pkg::PROX_EN_BIT];
    assign stat_rd = reg_rd && (reg_addr == lpt_pkg::ADDR_STATUS);

    // negative difference clamps to zero rather than wrapping to a huge reading
    assign amb_diff  = {1'b0, green_data} - {1'b0, ir_data};
    assign amb_value = amb_diff[lpt_pkg::LIMIT_W] ? '0 : amb_diff[lpt_pkg::LIMIT_W-1:0];
    assign amb_hit   = (amb_value > s_q.amb_up) || (amb_value < s_q.amb_lo);

    assign prox_hit = s_q.prox_above ? (prox_data > s_q.prox_limit)
                                     : (prox_data < s_q.prox_limit);

    lpt_persist u_amb_pers (
        .clock  (clock),
        .rst_n  (rst_n),
        .enable (amb_en),
        .sample (amb_done),
        .hit    (amb_hit),
        .sel    (s_q.persist[1:0]),
        .fire   (amb_fire)
    );

    lpt_persist u_prox_pers (
        .clock  (clock),
        .rst_n  (rst_n),
        .enable (prox_en),
        .sample (prox_done),
        .hit    (prox_hit),
        .sel    (s_q.persist[3:2]),
        .fire   (prox_fire)
    );

    always_comb begin
        s_d = s_q;
        if (reg_wr) begin
            unique case (reg_addr)
                lpt_pkg::ADDR_MAIN_CFG:  s_d.main_cfg = reg_wdata;
                lpt_pkg::ADDR_AMB_UP_HI: begin
                    s_d.amb_up[13:8] = reg_wdata[lpt_pkg::LIMIT_HI_W-1:0];
                end
                lpt_pkg::ADDR_AMB_UP_LO: s_d.amb_up[7:0] = reg_wdata;
                lpt_pkg::ADDR_AMB_LO_HI: begin
                    s_d.amb_lo[13:8] = reg_wdata[lpt_pkg::LIMIT_HI_W-1:0];
                end
                lpt_pkg::ADDR_AMB_LO_LO: s_d.amb_lo[7:0] = reg_wdata;
                lpt_pkg::ADDR_PERSIST:   s_d.persist = reg_wdata[3:0];
                lpt_pkg::ADDR_PROX_DIR:  s_d.prox_above = reg_wdata[lpt_pkg::PROX_DIR_BIT];
                lpt_pkg::ADDR_PROX_LIM:  s_d.prox_limit = reg_wdata;
                lpt_pkg::ADDR_GREEN_ADJ: s_d.green_adj = reg_wdata;
                lpt_pkg::ADDR_IR_ADJ:    s_d.ir_adj = reg_wdata;
                default: ;
            endcase
        end

        // set wins over the status-read clear so no event is lost
        s_d.amb_flag  = amb_en && ((amb_fire || (amb_done && ambient_overrange))
                        || (s_q.amb_flag && !stat_rd));
        s_d.prox_flag = prox_en && (prox_fire || (s_q.prox_flag && !stat_rd));
        s_d.pwr_flag  = s_q.pwr_flag && !stat_rd;

        // the pin follows the next flag state so it drops with the clearing read
        s_d.irq_oe = s_d.amb_flag || s_d.prox_flag;

        if (reg_rd) begin
            unique case (reg_addr)
                lpt_pkg::ADDR_STATUS: begin
                    s_d.rdata = '0;
                    s_d.rdata[lpt_pkg::AMB_FLAG_BIT]  = s_q.amb_flag;
                    s_d.rdata[lpt_pkg::PROX_FLAG_BIT] = s_q.prox_flag;
                    s_d.rdata[lpt_pkg::PWR_FLAG_BIT]  = s_q.pwr_flag;
                end
                lpt_pkg::ADDR_MAIN_CFG:  s_d.rdata = s_q.main_cfg;
                lpt_pkg::ADDR_AMB_UP_HI: s_d.rdata = {2'h0, s_q.amb_up[13:8]};
                lpt_pkg::ADDR_AMB_UP_LO: s_d.rdata = s_q.amb_up[7:0];
                lpt_pkg::ADDR_AMB_LO_HI: s_d.rdata = {2'h0, s_q.amb_lo[13:8]};
                lpt_pkg::ADDR_AMB_LO_LO: s_d.rdata = s_q.amb_lo[7:0];
                lpt_pkg::ADDR_PERSIST:   s_d.rdata = {4'h0, s_q.persist};
                lpt_pkg::ADDR_PROX_DIR: begin
                    s_d.rdata = '0;
                    s_d.rdata[lpt_pkg::PROX_DIR_BIT] = s_q.prox_above;
                end
                lpt_pkg::ADDR_PROX_LIM:  s_d.rdata = s_q.prox_limit;
                lpt_pkg::ADDR_GREEN_ADJ: s_d.rdata = ~s_q.green_adj;
                lpt_pkg::ADDR_IR_ADJ:    s_d.rdata = ~s_q.ir_adj;
                default:                 s_d.rdata = '0;
            endcase
        end

        // trims take effect only once the host has dropped the factory select
        if (s_q.main_cfg[lpt_pkg::TRIM_SEL_BIT]) begin
            s_d.green_gain = factory_green;
            s_d.ir_gain    = factory_ir;
        end else begin
            s_d.green_gain = s_q.green_adj[lpt_pkg::GREEN_GAIN_W-1:0];
            s_d.ir_gain    = {s_q.ir_adj, 1'b0};
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q.amb_up     <= '0;
            s_q.amb_lo     <= '0;
            s_q.persist    <= '0;
            s_q.prox_above <= 1'b0;
            s_q.prox_limit <= lpt_pkg::REG_RST;
            s_q.main_cfg   <= lpt_pkg::MAIN_CFG_RST;
            s_q.green_adj  <= lpt_pkg::TRIM_RST;
            s_q.ir_adj     <= lpt_pkg::TRIM_RST;
            s_q.amb_flag   <= 1'b0;
            s_q.prox_flag  <= 1'b0;
            s_q.pwr_flag   <= 1'b1;
            s_q.irq_oe     <= 1'b0;
            s_q.rdata      <= lpt_pkg::REG_RST;
            s_q.green_gain <= '0;
            s_q.ir_gain    <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata  = s_q.rdata;
    assign irq_n_out  = 1'b0;
    assign irq_n_oe   = s_q.irq_oe;
    assign green_gain = s_q.green_gain;
    assign ir_gain    = s_q.ir_gain;

    // helper for assertions only
    assign irq_oe_hold = s_q.amb_flag || s_q.prox_flag;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    amb_overrange_a: assert property (
        amb_done && ambient_overrange && amb_en && !reg_wr |=> s_q.amb_flag)
        else $error("overrange did not set ambient flag");

    amb_first_event_a: assert property (
        amb_done && amb_hit && amb_en && !reg_wr && (s_q.persist[1:0] == 2'h0)
        |=> s_q.amb_flag)
        else $error("ambient flag missed first event");

    prox_above_a: assert property (
        prox_done && prox_en && s_q.prox_above && (prox_data > s_q.prox_limit)
        && (s_q.persist[3:2] == 2'h0) && !reg_wr |=> s_q.prox_flag)
        else $error("prox above event not flagged");

    prox_no_event_a: assert property (
        prox_done && prox_en && !s_q.prox_above && (prox_data >= s_q.prox_limit)
        && !s_q.prox_flag && !reg_wr |=> !s_q.prox_flag)
        else $error("prox flag set without event");

    status_clear_a: assert property (
        stat_rd && !amb_done && !reg_wr |=> !s_q.amb_flag && !s_q.pwr_flag)
        else $error("status read did not clear flags");

    disable_clear_a: assert property (
        !amb_en && !prox_en |=> !s_q.amb_flag && !s_q.prox_flag)
        else $error("flag set while channel disabled");

    flag_hold_a: assert property (
        s_q.amb_flag && !stat_rd && amb_en && !reg_wr |=> s_q.amb_flag)
        else $error("ambient flag dropped without clear");

    irq_pin_a: assert property (
        irq_n_oe == irq_oe_hold && irq_n_out == 1'b0)
        else $error("interrupt pin disagrees with flags");

    trim_read_a: assert property (
        reg_rd && (reg_addr == lpt_pkg::ADDR_GREEN_ADJ)
        |=> reg_rdata == ~$past(s_q.green_adj))
        else $error("green trim read not complemented");

    limit_high_a: assert property (
        reg_wr && (reg_addr == lpt_pkg::ADDR_AMB_UP_HI)
        |=> s_q.amb_up[13:8] == $past(reg_wdata[5:0]))
        else $error("upper limit high byte not stored");

    persist_reg_a: assert property (
        reg_wr && (reg_addr == lpt_pkg::ADDR_PERSIST)
        |=> s_q.persist == $past(reg_wdata[3:0]))
        else $error("persistence selector not stored");

    user_trim_a: assert property (
        !s_q.main_cfg[lpt_pkg::TRIM_SEL_BIT] |=> ##0 green_gain == $past(s_q.green_adj[6:0]))
        else $error("user green trim not applied");

    pwr_flag_a: assert property (
        $rose(rst_n) |-> s_q.pwr_flag)
        else $error("power restart flag not set by reset");

    amb_upper_a: assert property (
        amb_done && amb_en && (green_data > ir_data) && (s_q.persist[1:0] == 2'h0)
        && ((green_data - ir_data) > s_q.amb_up) |=> s_q.amb_flag)
        else $error("ambient above upper limit not flagged");

    amb_lower_a: assert property (
        amb_done && amb_en && (amb_value < s_q.amb_lo) && (s_q.persist[1:0] == 2'h0)
        |=> s_q.amb_flag)
        else $error("ambient below lower limit not flagged");

    amb_cnt_clear_a: assert property (
        amb_done && amb_en && !amb_hit
        |=> u_amb_pers.s_q.cnt == '0)
        else $error("ambient counter kept after quiet measurement");

    prox_cnt_clear_a: assert property (
        prox_done && prox_en && !prox_hit
        |=> u_prox_pers.s_q.cnt == '0)
        else $error("proximity counter kept after quiet measurement");

    amb_cnt_off_a: assert property (
        !amb_en
        |=> u_amb_pers.s_q.cnt == '0)
        else $error("ambient counter runs while disabled");

    prox_early_a: assert property (
        prox_done && prox_en && prox_hit && (s_q.persist[3:2] == 2'h1)
        && (u_prox_pers.s_q.cnt == '0) && !s_q.prox_flag
        |=> !s_q.prox_flag)
        else $error("proximity flag set before persistence met");

    amb_four_a: assert property (
        amb_done && amb_en && amb_hit && (s_q.persist[1:0] == 2'h2)
        && (u_amb_pers.s_q.cnt == 5'h03) |=> s_q.amb_flag)
        else $error("fourth ambient event not flagged");

    amb_sixteen_a: assert property (
        amb_done && amb_en && amb_hit && !ambient_overrange && !s_q.amb_flag
        && (s_q.persist[1:0] == 2'h3) && (u_amb_pers.s_q.cnt == 5'h0E) |=> !s_q.amb_flag)
        else $error("ambient flag set before sixteenth event");

    prox_below_a: assert property (
        prox_done && prox_en && !s_q.prox_above && (prox_data < s_q.prox_limit)
        && (s_q.persist[3:2] == 2'h1) && (u_prox_pers.s_q.cnt == 5'h01) |=> s_q.prox_flag)
        else $error("prox below event not flagged");

    status_bits_a: assert property (
        reg_rd && (reg_addr == lpt_pkg::ADDR_STATUS)
        |=> reg_rdata[1:0] == $past({s_q.prox_flag, s_q.amb_flag}))
        else $error("status bits disagree with flags");

    ir_trim_read_a: assert property (
        reg_rd && (reg_addr == lpt_pkg::ADDR_IR_ADJ)
        |=> reg_rdata == ~$past(s_q.ir_adj))
        else $error("ir trim read not complemented");

    user_ir_trim_a: assert property (
        !s_q.main_cfg[lpt_pkg::TRIM_SEL_BIT]
        |=> ir_gain == {$past(s_q.ir_adj), 1'b0})
        else $error("user ir trim not applied");

    factory_trim_a: assert property (
        s_q.main_cfg[lpt_pkg::TRIM_SEL_BIT]
        |=> green_gain == $past(factory_green) && ir_gain == $past(factory_ir))
        else $error("factory trims not applied");

    amb_off_a: assert property (
        !amb_en
        |=> !s_q.amb_flag)
        else $error("ambient flag set while disabled");

    prox_off_a: assert property (
        !prox_en
        |=> !s_q.prox_flag)
        else $error("proximity flag set while disabled");

    prox_hold_a: assert property (
        s_q.prox_flag && prox_en && !stat_rd
        |=> s_q.prox_flag)
        else $error("proximity flag dropped without clear");

    enable_bits_a: assert property (
        reg_wr && (reg_addr == lpt_pkg::ADDR_MAIN_CFG)
        |=> amb_en == $past(reg_wdata[lpt_pkg::AMB_EN_BIT])
            && prox_en == $past(reg_wdata[lpt_pkg::PROX_EN_BIT]))
        else $error("interrupt enables not taken from main config");

    pwr_no_set_a: assert property (
        !s_q.pwr_flag
        |=> !s_q.pwr_flag)
        else $error("power restart flag set without reset");

    lower_high_a: assert property (
        reg_wr && (reg_addr == lpt_pkg::ADDR_AMB_LO_HI)
        |=> s_q.amb_lo[13:8] == $past(reg_wdata[5:0]))
        else $error("lower limit high byte not stored");

    amb_flag_cov: cover property ($rose(s_q.amb_flag));
    prox_flag_cov: cover property ($rose(s_q.prox_flag));
    irq_clear_cov: cover property (irq_n_oe ##1 stat_rd ##1 !irq_n_oe);
    pers16_cov: cover property ((s_q.persist[1:0] == 2'h3) && amb_fire);
    prox_pers_cov: cover property ((s_q.persist[3:2] == 2'h1) && prox_fire);

endmodule : lpt_core

// ### bench/lpt_host_model.sv
`timescale 1ns/100ps
module lpt_host_model (
    input  wire logic       clock,
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // strobes move at the falling edge so the core samples settled values
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clock);
        reg_wr    = 1'b0;
        reg_wdata = ~d; // released data must not look valid
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clock);
        reg_rd   = 1'b0;
        d        = reg_rdata;
    endtask : rd

    // window must suit the chosen resolution
    task automatic set_window(input logic [15:0] up, input logic [15:0] lo);
        wr(lpt_pkg::ADDR_AMB_UP_HI, up[15:8]);
        wr(lpt_pkg::ADDR_AMB_UP_LO, up[7:0]);
        wr(lpt_pkg::ADDR_AMB_LO_HI, lo[15:8]);
        wr(lpt_pkg::ADDR_AMB_LO_LO, lo[7:0]);
    endtask : set_window

    // trims first, select cleared only afterwards
    task automatic set_trims(input logic [7:0] g, input logic [7:0] ir, input logic [7:0] cfg);
        wr(lpt_pkg::ADDR_GREEN_ADJ, g);
        wr(lpt_pkg::ADDR_IR_ADJ, ir);
        wr(lpt_pkg::ADDR_MAIN_CFG, cfg);
    endtask : set_trims
endmodule : lpt_host_model

// ### bench/light_prox_threshold_irq_test.sv
`timescale 1ns/100ps
module light_prox_threshold_irq_test;
    logic        clock, rst_n, reg_wr, reg_rd, amb_done, ambient_overrange, prox_done;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, prox_data, rv;
    logic [13:0] green_data, ir_data;
    logic        irq_n_out, irq_n_oe, irq_pin;
    logic [6:0]  green_gain;
    logic [8:0]  ir_gain;
    int          fail_count, compares;

    assign irq_pin = irq_n_oe ? irq_n_out : 1'b1; // pull-up on the open-drain line

    lpt_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    lpt_core uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .amb_done(amb_done),
        .green_data(green_data), .ir_data(ir_data), .ambient_overrange(ambient_overrange),
        .prox_done(prox_done), .prox_data(prox_data), .factory_green(7'h2A),
        .factory_ir(9'h155), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
        .green_gain(green_gain), .ir_gain(ir_gain));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        host.rd(a, rv);
        chk("reg_rdata", {8'h00, e}, {8'h00, rv & m});
    endtask : rd_chk

    task automatic amb(input logic [13:0] g, input logic [13:0] i, input logic o);
        @(negedge clock);
        {amb_done, green_data, ir_data, ambient_overrange} = {1'b1, g, i, o};
        @(negedge clock);
        {amb_done, green_data, ir_data, ambient_overrange} = {1'b0, ~g, ~i, ~o};
    endtask : amb

    task automatic prox(input logic [7:0] d);
        @(negedge clock);
        {prox_done, prox_data} = {1'b1, d};
        @(negedge clock);
        {prox_done, prox_data} = {1'b0, ~d};
    endtask : prox

    task automatic t_reset();
        rd_chk(lpt_pkg::ADDR_STATUS, 8'h04, 8'h04);
        chk("green_gain", 16'h002A, {9'h000, green_gain});
        chk("ir_gain", 16'h0155, {7'h00, ir_gain});
        rd_chk(lpt_pkg::ADDR_PERSIST, 8'hFF, 8'h00);
        rd_chk(lpt_pkg::ADDR_GREEN_ADJ, 8'hFF, 8'h7F);
        rd_chk(lpt_pkg::ADDR_IR_ADJ, 8'hFF, 8'h7F);
        rd_chk(8'h0D, 8'hFF, 8'h00);
    endtask : t_reset

    task automatic t_window();
        host.set_window(16'hC100, 16'h0010);
        rd_chk(lpt_pkg::ADDR_AMB_UP_HI, 8'hFF, 8'h01);
        host.wr(lpt_pkg::ADDR_MAIN_CFG, 8'h01);
        amb(14'h0200, 14'h0150, 1'b0);
        chk("irq_pin", 16'h1, {15'h0, irq_pin});
        amb(14'h0200, 14'h00F0, 1'b0);
        chk("irq_pin", 16'h0, {15'h0, irq_pin});
        amb(14'h0050, 14'h0000, 1'b0);
        chk("irq_pin", 16'h0, {15'h0, irq_pin});
        rd_chk(lpt_pkg::ADDR_STATUS, 8'h03, 8'h01);
        chk("irq_pin", 16'h1, {15'h0, irq_pin});
        amb(14'h0008, 14'h0000, 1'b0);
        chk("irq_pin", 16'h0, {15'h0, irq_pin});
        rd_chk(lpt_pkg::ADDR_STATUS, 8'h03, 8'h01);
    endtask : t_window

    task automatic t_persist();
        int need [4] = '{1, 2, 4, 16};
        for (int s = 0; s < 4; s++) begin
            host.wr(lpt_pkg::ADDR_PERSIST, 8'(s));
            amb(14'h0050, 14'h0000, 1'b0);
            // a quiet cycle between runs must restart the count
            for (int k = 1; k < need[s]; k++) amb(14'h0300, 14'h0000, 1'b0);
            amb(14'h0050, 14'h0000, 1'b0);
            for (int k = 1; k < need[s]; k++) amb(14'h0300, 14'h0000, 1'b0);
            chk("irq_pin", 16'h1, {15'h0, irq_pin});
            amb(14'h0300, 14'h0000, 1'b0);
            chk("irq_pin", 16'h0, {15'h0, irq_pin});
            rd_chk(lpt_pkg::ADDR_STATUS, 8'h03, 8'h01);
        end
    endtask : t_persist

    task automatic t_prox();
        host.wr(lpt_pkg::ADDR_PERSIST, 8'h04);
        host.wr(lpt_pkg::ADDR_PROX_LIM, 8'h80);
        host.wr(lpt_pkg::ADDR_PROX_DIR, 8'h40);
        host.wr(lpt_pkg::ADDR_MAIN_CFG, 8'h02);
        amb(14'h3000, 14'h0000, 1'b1);
        chk("irq_pin", 16'h1, {15'h0, irq_pin});
        prox(8'h81);
        prox(8'h80);
        prox(8'h81);
        chk("irq_pin", 16'h1, {15'h0, irq_pin});
        prox(8'h81);
        chk("irq_pin", 16'h0, {15'h0, irq_pin});
        rd_chk(lpt_pkg::ADDR_STATUS, 8'h03, 8'h02);
        host.wr(lpt_pkg::ADDR_PROX_DIR, 8'h00);
        prox(8'h80);
        prox(8'h80);
        chk("irq_pin", 16'h1, {15'h0, irq_pin});
        prox(8'h7F);
        prox(8'h7F);
        chk("irq_pin", 16'h0, {15'h0, irq_pin});
        rd_chk(lpt_pkg::ADDR_STATUS, 8'h03, 8'h02);
    endtask : t_prox

    task automatic t_ovr();
        host.wr(lpt_pkg::ADDR_PERSIST, 8'h00);
        host.wr(lpt_pkg::ADDR_MAIN_CFG, 8'h03);
        amb(14'h0050, 14'h0000, 1'b1);
        chk("irq_pin", 16'h0, {15'h0, irq_pin});
        host.wr(lpt_pkg::ADDR_MAIN_CFG, 8'h00);
        // the flag drops one cycle after the disabling write lands
        @(negedge clock);
        chk("irq_pin", 16'h1, {15'h0, irq_pin});
        rd_chk(lpt_pkg::ADDR_STATUS, 8'h03, 8'h00);
    endtask : t_ovr

    task automatic t_trim();
        host.set_trims(8'h55, 8'h33, 8'h00);
        rd_chk(lpt_pkg::ADDR_GREEN_ADJ, 8'hFF, 8'hAA);
        rd_chk(lpt_pkg::ADDR_IR_ADJ, 8'hFF, 8'hCC);
        chk("green_gain", 16'h0055, {9'h000, green_gain});
        chk("ir_gain", 16'h0066, {7'h00, ir_gain});
    endtask : t_trim

    task automatic t_rerst();
        @(negedge clock);
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        chk("irq_pin", 16'h1, {15'h0, irq_pin});
        rd_chk(lpt_pkg::ADDR_STATUS, 8'h07, 8'h04);
        chk("green_gain", 16'h002A, {9'h000, green_gain});
    endtask : t_rerst

    task automatic finish_test();
        if (fail_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    initial begin
        {rst_n, amb_done, ambient_overrange, prox_done} = 4'h0;
        {green_data, ir_data, prox_data} = '0;
        fail_count = 0;
        compares = 0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        t_reset();
        t_window();
        t_persist();
        t_prox();
        t_ovr();
        t_trim();
        t_rerst();
        finish_test();
    end
endmodule : light_prox_threshold_irq_test
